// ---- core/aice_exec.sv ----
// executes add-immediate, and, bit clear/set, bit test skip, call via acc
// assumes instructions arrive decoded, one per cycle, with register read
// data for the addressed register valid in the same cycle
//
// Operation
// - add with carry: acc+imm+c to acc
// - add immediate sets z, dc, c
// - and with register, only z changes
// - dest bit 0 to acc, 1 to register
// - and immediate into acc, sets z
// - bit clear, flags untouched, one cycle
// - bit set, flags untouched, one cycle
// - test bit skip when bit clear
// - skip flushes prefetched word, two cycles
// - call pushes pc plus one, two cycles
// - call target from table pointer and acc
// - carry set on carry out
`timescale 1ns/1ps
`default_nettype none
module aice_exec
	import aice_pkg::*;
#(
	parameter int DEPTH = aice_pkg::STK_DEPTH
)
(
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         instr_valid,
	input  wire aice_pkg::aice_op_e           instr_op,
	input  wire logic [aice_pkg::DATA_W-1:0]  instr_imm,
	input  wire logic [aice_pkg::RADDR_W-1:0] instr_reg,
	input  wire logic [2:0]                   instr_bit,
	input  wire logic                         instr_dest,
	input  wire logic [aice_pkg::DATA_W-1:0]  reg_rdata,
	input  wire logic [aice_pkg::DATA_W-1:0]  table_high_pointer,
	output logic      [aice_pkg::RADDR_W-1:0] reg_addr,
	output logic                              reg_we,
	output logic      [aice_pkg::DATA_W-1:0]  reg_wdata,
	output logic      [aice_pkg::DATA_W-1:0]  accumulator,
	output logic                              zero_flag,
	output logic                              digit_carry_flag,
	output logic                              carry_flag,
	output logic      [aice_pkg::PC_W-1:0]    pc,
	output logic                              pc_load,
	output logic                              fetch_discard,
	output logic                              busy,
	output logic      [aice_pkg::SP_W-1:0]    stack_ptr,
	output logic      [aice_pkg::PC_W-1:0]    stack_top
);
	import aice_pkg::*;

	typedef struct packed
	{
		aice_st_e                   st;
		logic [DATA_W-1:0]          acc;
		logic                       z;
		logic                       dc;
		logic                       c;
		logic [PC_W-1:0]            pc;
		logic                       pc_load;
		logic                       discard;
		logic [SP_W-1:0]            sp;
		logic                       we;
		logic [RADDR_W-1:0]         waddr;
		logic [DATA_W-1:0]          wdata;
	} aice_state_s;

	aice_state_s         s_q;
	aice_state_s         s_d;
	logic [PC_W-1:0]     stk_q [DEPTH];
	logic                push;
	logic [PC_W-1:0]     ret_addr;

	// 9-bit sum with the nibble carry on top; only the nibble carry-out is
	// kept, so the result is exactly sum plus one bit and nothing is truncated
	function automatic logic [DATA_W+1:0] aice_add(
		input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] b,
		input logic              cin
	);
		logic [DATA_W:0]  sum;
		logic [DCY_POS:0] nib;
		sum = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
		nib = {1'b0, a[NIB_MSB:0]} + {1'b0, b[NIB_MSB:0]}
			+ {{NIB_MSB+1{1'b0}}, cin};
		return {nib[DCY_POS], sum};
	endfunction

	logic [DATA_W+1:0]       add_r;
	logic [DATA_W-1:0]       and_r;
	logic                    cin;
	logic                    use_c;

	always_comb
	begin
		s_d = s_q;
		s_d.we = 1'b0;
		s_d.pc_load = 1'b0;
		s_d.discard = 1'b0;
		push = 1'b0;
		ret_addr = s_q.pc + PC_INC;
		use_c = (instr_op == AICE_OP_ADD_IMMC);
		cin = use_c ? s_q.c : 1'b0;
		add_r = aice_add(s_q.acc, instr_imm, cin);
		and_r = s_q.acc & ((instr_op == AICE_OP_AND_REG) ? reg_rdata : instr_imm);
		if (s_q.st == AICE_ST_FLUSH)
		begin
			// second cycle: the prefetched word is dropped, acts as no-op
			s_d.st = AICE_ST_RUN;
		end
		else if (instr_valid)
		begin
			s_d.pc = s_q.pc + PC_INC;
			case (instr_op)
				AICE_OP_ADD_IMMC, AICE_OP_ADD_IMM:
				begin
					s_d.acc = add_r[DATA_W-1:0];
					s_d.c = add_r[DATA_W];
					s_d.dc = add_r[DATA_W+1];
					s_d.z = (add_r[DATA_W-1:0] == ZERO8);
				end
				AICE_OP_AND_REG:
				begin
					s_d.z = (and_r == ZERO8);
					if (instr_dest)
					begin
						s_d.we = 1'b1;
						s_d.waddr = instr_reg;
						s_d.wdata = and_r;
					end
					else
					begin
						s_d.acc = and_r;
					end
				end
				AICE_OP_AND_IMM:
				begin
					s_d.acc = and_r;
					s_d.z = (and_r == ZERO8);
				end
				AICE_OP_BIT_CLR, AICE_OP_BIT_SET:
				begin
					s_d.we = 1'b1;
					s_d.waddr = instr_reg;
					s_d.wdata = reg_rdata;
					s_d.wdata[instr_bit] = (instr_op == AICE_OP_BIT_SET);
				end
				AICE_OP_TST_SKC:
				begin
					if (!reg_rdata[instr_bit])
					begin
						s_d.st = AICE_ST_FLUSH;
						s_d.discard = 1'b1;
						s_d.pc = s_q.pc + PC_INC + PC_INC;
					end
				end
				AICE_OP_CALL_ACC:
				begin
					push = 1'b1;
					s_d.sp = s_q.sp + SP_INC;
					s_d.pc = {table_high_pointer[TABLE_HIGH_POINTER_LSB:0], s_q.acc};
					s_d.pc_load = 1'b1;
					s_d.discard = 1'b1;
					s_d.st = AICE_ST_FLUSH;
				end
				default:
				begin
					s_d.st = AICE_ST_RUN;
				end
			endcase
		end
		if (rst)
		begin
			s_d = '0;
			s_d.st = AICE_ST_RUN;
			s_d.acc = ACC_RST;
			s_d.pc = PC_RST;
			s_d.sp = SP_RST;
		end
	end

	always_ff @(posedge clk)
	begin
		s_q <= s_d;
	end

	// return stack memory; wraps silently when overfilled
	always_ff @(posedge clk)
	begin
		if (push && !rst)
		begin
			stk_q[s_q.sp] <= ret_addr;
		end
	end

	assign reg_addr         = s_q.waddr;
	assign reg_we           = s_q.we;
	assign reg_wdata        = s_q.wdata;
	assign accumulator      = s_q.acc;
	assign zero_flag        = s_q.z;
	assign digit_carry_flag = s_q.dc;
	assign carry_flag       = s_q.c;
	assign pc               = s_q.pc;
	assign pc_load          = s_q.pc_load;
	assign fetch_discard    = s_q.discard;
	assign busy             = (s_q.st == AICE_ST_FLUSH);
	assign stack_ptr        = s_q.sp;
	// top of stack is the last written entry; zero whenever the pointer is zero, before any call or after a wrap
	assign stack_top        = (s_q.sp == SP_RST) ? PC_RST
		: stk_q[s_q.sp - SP_INC];
endmodule
`default_nettype wire

// ---- core/aice_pkg.sv ----
// package for the instruction execution slice: opcodes, widths, flags
// assumes a single core clock and synchronous active-high reset
package aice_pkg;
	localparam int DATA_W   = 8;
	localparam int RADDR_W  = 6;
	localparam int PC_W     = 10;
	localparam int STK_DEPTH = 8;
	localparam int SP_W     = 3;
	localparam int NIB_MSB  = 3;
	localparam int DCY_POS  = 4;
	localparam int TABLE_HIGH_POINTER_LSB = 1;

	// operation codes on the decoded-instruction port
	typedef enum logic [3:0]
	{
		AICE_OP_NOP      = 4'h0,
		AICE_OP_ADD_IMMC = 4'h1,
		AICE_OP_ADD_IMM  = 4'h2,
		AICE_OP_AND_REG  = 4'h3,
		AICE_OP_AND_IMM  = 4'h4,
		AICE_OP_BIT_CLR  = 4'h5,
		AICE_OP_BIT_SET  = 4'h6,
		AICE_OP_TST_SKC  = 4'h7,
		AICE_OP_CALL_ACC = 4'h8
	} aice_op_e;

	// execution phase
	typedef enum logic [0:0]
	{
		AICE_ST_RUN   = 1'b0,
		AICE_ST_FLUSH = 1'b1
	} aice_st_e;

	localparam logic [7:0]      ACC_RST = 8'h00;
	localparam logic [9:0]      PC_RST  = 10'h000;
	localparam logic [9:0]      PC_INC  = 10'h001;
	localparam logic [2:0]      SP_RST  = 3'h0;
	localparam logic [2:0]      SP_INC  = 3'h1;
	localparam logic [7:0]      ZERO8   = 8'h00;
endpackage

// ---- verif/aice_properties.sv ----
// assertions on the execution slice ports
// bound to aice_exec, single clock
`timescale 1ns/1ps
`default_nettype none
module aice_properties
	import aice_pkg::*;
(
	input wire logic               clk,
	input wire logic               rst,
	input wire logic               instr_valid,
	input wire aice_pkg::aice_op_e instr_op,
	input wire logic               busy,
	input wire logic               fetch_discard,
	input wire logic               pc_load,
	input wire logic               reg_we,
	input wire logic               zero_flag,
	input wire logic               digit_carry_flag,
	input wire logic               carry_flag,
	input wire logic [2:0]         stack_ptr
);
	wire logic tk = instr_valid && !busy;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_call;
		tk && instr_op == AICE_OP_CALL_ACC;
	endsequence
	sequence s_bit;
		tk && instr_op inside {AICE_OP_BIT_CLR, AICE_OP_BIT_SET};
	endsequence
	AST_CALL: assert property (s_call |=> pc_load && fetch_discard && busy)
		else $error("call pulses missing");
	AST_PUSH: assert property (s_call |=> stack_ptr == $past(stack_ptr) + 3'h1)
		else $error("stack pointer did not advance");
	AST_BWE: assert property (s_bit |=> reg_we)
		else $error("bit op without write");
	AST_FLG: assert property (s_bit |=> $stable({zero_flag,
		digit_carry_flag, carry_flag})) else $error("flags moved");
	AST_FLGC: assert property (s_call |=> $stable({zero_flag,
		digit_carry_flag, carry_flag})) else $error("call moved flags");
	AST_ANDF: assert property (tk && instr_op inside {AICE_OP_AND_REG,
		AICE_OP_AND_IMM} |=> $stable({digit_carry_flag, carry_flag}))
		else $error("and moved carries");
	AST_DISC: assert property (fetch_discard |-> busy)
		else $error("discard outside flush");
	AST_ONE: assert property (busy |=> !busy)
		else $error("flush longer than one cycle");
	AST_NOP: assert property (busy |=> !reg_we && !pc_load)
		else $error("flushed word executed");
endmodule
bind aice_exec aice_properties i_aice_properties (.clk, .rst, .instr_valid,
	.instr_op, .busy, .fetch_discard, .pc_load, .reg_we, .zero_flag,
	.digit_carry_flag, .carry_flag, .stack_ptr);
`default_nettype wire

// ---- verif/aice_regfile_model.sv ----
// register file beside the slice: combinational read, clocked write-back
// all registers start at 8'hAF so reads are never unknown
`timescale 1ns/1ps
`default_nettype none
module aice_regfile_model (
	input wire logic       clk,
	input wire logic [5:0] raddr,
	input wire logic [5:0] waddr,
	input wire logic       we,
	input wire logic [7:0] wdata,
	output logic     [7:0] rdata
);
	logic [7:0] mem [64];
	initial foreach (mem[i]) mem[i] = 8'hAF;
	assign rdata = mem[raddr];
	always @(posedge clk) if (we) mem[waddr] <= wdata;
endmodule
`default_nettype wire

// ---- verif/tb_aice_exec.sv ----
// self-checking bench for aice_exec with a register file model
// assumes register 5 starts at 8'hAF
`timescale 1ns/1ps
`default_nettype none
module tb_aice_exec;
	import aice_pkg::*;
	logic clk = 0, rst = 1, v = 0, ds = 0, we, pl, fd, bz, z, h, c;
	aice_op_e op = AICE_OP_NOP;
	logic [7:0] imm = 8'h00, th = 8'h02, rd, wd, acc;
	logic [5:0] ra = 6'h05, wa;
	logic [2:0] bs = 3'h0, sp;
	logic [9:0] pc, st, epc = 10'h000;
	int fail_count = 0, cmp_count = 0;
	always #2.5 clk = ~clk;
	aice_exec i_aice_exec (.clk(clk), .rst(rst), .instr_valid(v),
		.instr_op(op), .instr_imm(imm), .instr_reg(ra), .instr_bit(bs),
		.instr_dest(ds), .reg_rdata(rd), .table_high_pointer(th),
		.reg_addr(wa), .reg_we(we), .reg_wdata(wd), .accumulator(acc),
		.zero_flag(z), .digit_carry_flag(h), .carry_flag(c), .pc(pc),
		.pc_load(pl), .fetch_discard(fd), .busy(bz), .stack_ptr(sp),
		.stack_top(st));
	aice_regfile_model i_aice_regfile_model (.clk(clk), .raddr(ra),
		.waddr(wa), .we(we), .wdata(wd), .rdata(rd));
	task automatic chk(logic [23:0] e, logic [23:0] g);
		cmp_count++;
		if (e !== g)
		begin
			fail_count++;
			$display("wrong value at %0t: %h %h", $time, e, g);
		end
	endtask
	task automatic run(aice_op_e o, logic [7:0] i, logic [2:0] b, logic d);
		op <= o;
		imm <= i;
		bs <= b;
		ds <= d;
		v <= 1'b1;
		@(posedge clk);
		v <= 1'b0;
		#1;
		epc = epc + 10'h001;
	endtask
	// write-back lands one edge late, so a gap avoids a stale read
	task automatic idle;
		@(posedge clk);
		#1;
	endtask
	task automatic tally_and_finish;
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(0, {acc, z, h, c, pc, sp});
		run(AICE_OP_ADD_IMM, 8'h12, 0, 0);
		run(AICE_OP_ADD_IMM, 8'hFF, 0, 0);
		chk({8'h11, 3'b011}, {acc, z, h, c});
		run(AICE_OP_ADD_IMMC, 8'h34, 0, 0);
		chk({8'h46, 3'b000}, {acc, z, h, c});
		run(AICE_OP_ADD_IMM, 8'hBA, 0, 0);
		chk({8'h00, 3'b111}, {acc, z, h, c});
		run(AICE_OP_ADD_IMM, 8'h5A, 0, 0);
		run(AICE_OP_AND_REG, 8'h00, 0, 1);
		chk({8'h0A, 1'b1, 8'h5A, 1'b0}, {wd, we, acc, z});
		idle;
		run(AICE_OP_AND_REG, 8'h00, 0, 0);
		chk({1'b0, 8'h0A, 1'b0}, {we, acc, z});
		run(AICE_OP_AND_IMM, 8'h50, 0, 0);
		chk({8'h00, 1'b1}, {acc, z});
		run(AICE_OP_BIT_SET, 8'h00, 2, 0);
		chk({1'b1, 8'h0E}, {we, wd});
		idle;
		run(AICE_OP_BIT_CLR, 8'h00, 3, 0);
		chk({1'b1, 8'h06}, {we, wd});
		idle;
		run(AICE_OP_TST_SKC, 8'h00, 1, 0);
		chk({2'b00, epc}, {fd, bz, pc});
		run(AICE_OP_TST_SKC, 8'h00, 0, 0);
		epc = epc + 10'h001;
		chk({2'b11, epc}, {fd, bz, pc});
		run(AICE_OP_ADD_IMM, 8'h34, 0, 0);
		epc = epc - 10'h001;
		chk({8'h00, 1'b0, epc}, {acc, bz, pc});
		run(AICE_OP_ADD_IMM, 8'h34, 0, 0);
		run(AICE_OP_CALL_ACC, 8'h00, 0, 0);
		chk({2'b11, 10'h234}, {pl, fd, pc});
		chk({3'h1, epc}, {sp, st});
		idle;
		tally_and_finish;
	end
	initial
	begin
		#10000;
		fail_count++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
